/* File: albs_adapter_end.sv */
// Adapter end of the adapter link bring-up sequencer.
// Assumes the equipment end drives the tick and the adapter reset line.
module albs_adapter_end
    import albs_pkg::*;
#(
    parameter int GENERAL_RESPONSE_TIMEOUT = RESPONSE_TIMEOUT_MS,
    parameter int ADAPTER_CONFIRM_TIMEOUT = ADAPTER_CONFIRM_MS,
    parameter int INIT_PERIOD = ADAPTER_INIT_MS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Link toward the equipment
    albs_link_if.adapter link,
    // Identity and retained objects, sampled after reset release
    input wire logic [7:0] adapter_type_in,
    input wire logic retained_valid_in,
    input wire logic [7:0] retained_sig_in,
    // Status
    output logic [8:0] ad_state_out,
    output logic has_objects_out
);

    // ****************************************
    // Types and local signals
    // ****************************************
    typedef enum logic [8:0] {
        A_CONF = 9'h001,
        A_STANDBY = 9'h002,
        A_INIT = 9'h004,
        A_DONE_WAIT = 9'h008,
        A_INQ = 9'h010,
        A_INQ_DONE = 9'h020,
        A_STARTUP = 9'h040,
        A_NORMAL = 9'h080,
        A_UNREC = 9'h100
    } albs_ad_state_t;

    albs_ad_state_t state_q;
    logic [TIMER_W-1:0] tmr_q;
    logic pend_q;
    logic load_q;
    logic retry_q;
    logic has_obj_q;
    logic [7:0] obj_sig_q;
    logic [7:0] idx_q;
    logic ad_valid_q;
    albs_msg_t ad_code_q;
    logic [ARG_W-1:0] ad_arg_q;
    logic rx;
    logic [TIMER_W-1:0] limit;

    assign rx = link.eq_valid;
    assign limit = (state_q == A_CONF) ? TIMER_W'(ADAPTER_CONFIRM_TIMEOUT) : TIMER_W'(GENERAL_RESPONSE_TIMEOUT);

    // ****************************************
    // Sequencer
    // ****************************************
    // The link reset returns to confirmation but keeps stored objects, as they are nonvolatile
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= A_CONF;
            tmr_q <= '0;
            pend_q <= 1'b1;
            load_q <= 1'b1;
            retry_q <= 1'b0;
            has_obj_q <= 1'b0;
            obj_sig_q <= 8'h00;
            idx_q <= 8'h00;
            ad_valid_q <= 1'b0;
            ad_code_q <= MSG_NONE;
            ad_arg_q <= '0;
        end else begin
            ad_valid_q <= 1'b0;
            load_q <= 1'b0;
            if (load_q) begin
                has_obj_q <= retained_valid_in;
                obj_sig_q <= retained_sig_in;
            end
            if (link.tick && (tmr_q != '1)) begin
                tmr_q <= tmr_q + 1'b1;
            end
            if (!link.adapter_reset_n) begin
                state_q <= A_CONF;
                tmr_q <= '0;
                pend_q <= 1'b1;
                retry_q <= 1'b0;
            end else begin
                case (state_q)
                    A_CONF: begin
                        if (pend_q && !load_q) begin
                            pend_q <= 1'b0;
                            tmr_q <= '0;
                            ad_valid_q <= 1'b1;
                            ad_code_q <= MSG_CONF_REQ;
                            ad_arg_q <= {adapter_type_in, has_obj_q ? obj_sig_q : NO_OBJECTS};
                        end else if (rx && (link.eq_code == MSG_CONF_RSP)) begin
                            if (link.eq_arg[7:0] == RES_OBJ_MISMATCH || link.eq_arg[7:0] == RES_DISPOSE) begin
                                has_obj_q <= 1'b0;
                            end
                            state_q <= (link.eq_arg[7:0] == RES_DISPOSE) ? A_UNREC : A_STANDBY;
                        end else if (!pend_q && tmr_q >= limit) begin
                            tmr_q <= '0;
                            retry_q <= 1'b1;
                            if (retry_q) begin
                                has_obj_q <= 1'b0;
                                state_q <= A_UNREC;
                            end else begin
                                ad_valid_q <= 1'b1;
                            end
                        end
                    end
                    A_STANDBY, A_INIT: begin
                        if (rx && (link.eq_code == MSG_INIT_REQ)) begin
                            if (!link.eq_arg[ARG_KEEP_BIT]) begin
                                has_obj_q <= 1'b0;
                            end
                            tmr_q <= '0;
                            ad_valid_q <= 1'b1;
                            ad_code_q <= MSG_INIT_ACC;
                            ad_arg_q <= '0;
                            state_q <= A_INIT;
                        end else if (state_q == A_INIT && tmr_q >= TIMER_W'(INIT_PERIOD)) begin
                            tmr_q <= '0;
                            retry_q <= 1'b0;
                            ad_valid_q <= 1'b1;
                            ad_code_q <= MSG_INIT_DONE;
                            state_q <= A_DONE_WAIT;
                        end
                    end
                    A_DONE_WAIT, A_INQ, A_INQ_DONE, A_STARTUP: begin
                        if (rx && (link.eq_code == MSG_INIT_DONE_ACK) && (state_q == A_DONE_WAIT)
                                && (link.eq_arg[7:0] == RES_OK)) begin
                            tmr_q <= '0;
                            retry_q <= 1'b0;
                            ad_valid_q <= 1'b1;
                            idx_q <= 8'h00;
                            ad_code_q <= has_obj_q ? MSG_STARTUP : MSG_INQ_REQ;
                            ad_arg_q <= '0;
                            state_q <= has_obj_q ? A_STARTUP : A_INQ;
                        end else if (rx && (link.eq_code == MSG_INQ_RSP) && (state_q == A_INQ)) begin
                            tmr_q <= '0;
                            retry_q <= 1'b0;
                            ad_valid_q <= 1'b1;
                            if (link.eq_arg[ARG_LAST_BIT]) begin
                                ad_code_q <= MSG_INQ_DONE;
                                state_q <= A_INQ_DONE;
                            end else begin
                                idx_q <= idx_q + 8'h01;
                                ad_arg_q <= {8'h00, idx_q + 8'h01};
                            end
                        end else if (rx && (link.eq_code == MSG_INQ_DONE_ACK) && (state_q == A_INQ_DONE)) begin
                            tmr_q <= '0;
                            retry_q <= 1'b0;
                            has_obj_q <= 1'b1;
                            obj_sig_q <= link.eq_arg[7:0];
                            ad_valid_q <= 1'b1;
                            ad_code_q <= MSG_STARTUP;
                            ad_arg_q <= '0;
                            state_q <= A_STARTUP;
                        end else if (rx && (link.eq_code == MSG_STARTUP_ACK) && (state_q == A_STARTUP)) begin
                            state_q <= A_NORMAL;
                        end else if (tmr_q >= limit) begin
                            tmr_q <= '0;
                            retry_q <= 1'b1;
                            if (retry_q) begin
                                state_q <= A_STANDBY;
                            end else begin
                                ad_valid_q <= 1'b1;
                            end
                        end
                    end
                    A_NORMAL, A_UNREC: begin
                        state_q <= state_q;
                    end
                    default: begin
                        state_q <= A_CONF;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign link.ad_valid = ad_valid_q;
    assign link.ad_code = ad_code_q;
    assign link.ad_arg = ad_arg_q;
    assign ad_state_out = state_q;
    assign has_objects_out = has_obj_q;

endmodule

/* File: albs_equip_end.sv */
// Equipment end of the adapter link bring-up sequencer.
// Assumes the adapter end shares clk_in and answers over albs_link_if.
//
// Summary of operation
// - Confirm state ignores all but confirmation requests
// - Check type and objects, answer promptly
// - Mismatch reported in result field
// - Type mismatch: delay, reset adapter, wait
// - Third mismatch: dispose, wait, reset, unrecognized
// - No request in disposal wait: reset again
// - Third request timeout: discard, reset, unrecognized
// - Adapter requests after power-on, zero objects unless retained
// - Adapter acts on confirmation result
// - Adapter resends request once, then unrecognized
// - Send init request, retry once, stand-alone
// - Wait init period for completion, else stand-alone
// - Acknowledge init completion within general timeout
// - Adapter accepts init, discarding objects if asked
// - Adapter resends completion once, then standby
// - Adapter with objects sends startup notification
// - Acknowledge every startup notification promptly
// - Adapter inquires each object in turn
// - Adapter sends inquiry completion, then startup
// - Answer every inquiry and inquiry completion
// - First and general timeouts are three seconds
module albs_equip_end
    import albs_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int FIRST_RESPONSE_TIMEOUT = RESPONSE_TIMEOUT_MS,
    parameter int INIT_WAIT_PERIOD = INIT_WAIT_MS,
    parameter int CONFIRM_RESPONSE_TIMEOUT = CONFIRM_RESPONSE_MS,
    parameter int RESET_DELAY_PERIOD = RESET_DELAY_MS,
    parameter int DISPOSAL_WAIT_PERIOD = DISPOSAL_WAIT_MS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Link toward the adapter
    albs_link_if.equip link,
    // Expected adapter and object data
    input wire logic [7:0] exp_adapter_type_in,
    input wire logic [7:0] exp_obj_sig_in,
    input wire logic [7:0] num_objects_in,
    input wire logic keep_data_in,
    // Status
    output logic [8:0] eq_state_out,
    output logic iface_data_valid_out
);

    // ****************************************
    // Types and local signals
    // ****************************************
    typedef enum logic [8:0] {
        E_IFC = 9'h001,
        E_RST_DLY = 9'h002,
        E_DISPOSE = 9'h004,
        E_INIT_REQ = 9'h008,
        E_INIT_WAIT = 9'h010,
        E_CONSTRUCT = 9'h020,
        E_NORMAL = 9'h040,
        E_STANDALONE = 9'h080,
        E_UNREC = 9'h100
    } albs_eq_state_t;

    albs_eq_state_t state_q;
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic [TIMER_W-1:0] tmr_q;
    logic tmr_clr;
    logic [1:0] tmo_cnt_q;
    logic [1:0] mm_cnt_q;
    logic retry_q;
    logic rst_req_q;
    logic [3:0] rst_cnt_q;
    logic adp_rst_n_q;
    logic eq_valid_q;
    albs_msg_t eq_code_q;
    logic [ARG_W-1:0] eq_arg_q;
    logic iface_valid_q;
    logic rx;
    logic [7:0] rx_type;
    logic [7:0] rx_obj;

    assign rx = link.ad_valid;
    assign rx_type = link.ad_arg[ARG_W-1:ARG_TYPE_LSB];
    assign rx_obj = link.ad_arg[ARG_TYPE_LSB-1:0];
    assign tmr_clr = (state_q != E_IFC) && rx;

    // ****************************************
    // Shared time base
    // ****************************************
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q >= 32'(TICK_LEN - 1)) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // ****************************************
    // Adapter reset pulse
    // ****************************************
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_cnt_q <= 4'h0;
            adp_rst_n_q <= 1'b1;
        end else if (rst_req_q) begin
            rst_cnt_q <= RESET_PULSE_CYCLES - 4'h1;
            adp_rst_n_q <= 1'b0;
        end else if (rst_cnt_q != 4'h0) begin
            rst_cnt_q <= rst_cnt_q - 4'h1;
            adp_rst_n_q <= 1'b0;
        end else begin
            adp_rst_n_q <= 1'b1;
        end
    end

    // ****************************************
    // Sequencer, timer and messages
    // ****************************************
    // Answers go out the cycle after the request, far inside every response timeout
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= E_IFC;
            tmr_q <= '0;
            tmo_cnt_q <= 2'h0;
            mm_cnt_q <= 2'h0;
            retry_q <= 1'b0;
            rst_req_q <= 1'b0;
            eq_valid_q <= 1'b0;
            eq_code_q <= MSG_NONE;
            eq_arg_q <= '0;
            iface_valid_q <= 1'b1;
        end else begin
            eq_valid_q <= 1'b0;
            rst_req_q <= 1'b0;
            if (tmr_clr) begin
                tmr_q <= '0;
            end else if (tick_q && (tmr_q != '1)) begin
                tmr_q <= tmr_q + 1'b1;
            end
            case (state_q)
                E_IFC: begin
                    // Anything but a confirmation request is dropped here
                    if (rx && (link.ad_code == MSG_CONF_REQ)) begin
                        tmr_q <= '0;
                        eq_valid_q <= 1'b1;
                        eq_code_q <= MSG_CONF_RSP;
                        eq_arg_q[ARG_W-1:8] <= 8'h00;
                        if (rx_type != exp_adapter_type_in) begin
                            if (mm_cnt_q == RETRY_LIMIT - 2'h1) begin
                                eq_arg_q[7:0] <= RES_DISPOSE;
                                state_q <= E_DISPOSE;
                            end else begin
                                mm_cnt_q <= mm_cnt_q + 2'h1;
                                eq_arg_q[7:0] <= RES_TYPE_MISMATCH;
                                state_q <= E_RST_DLY;
                            end
                        end else if (rx_obj != exp_obj_sig_in) begin
                            eq_arg_q[7:0] <= RES_OBJ_MISMATCH;
                            state_q <= E_INIT_REQ;
                        end else begin
                            eq_arg_q[7:0] <= RES_OK;
                            state_q <= E_INIT_REQ;
                        end
                    end else if (tmr_q >= TIMER_W'(DISPOSAL_WAIT_PERIOD)) begin
                        tmr_q <= '0;
                        rst_req_q <= 1'b1;
                        if (tmo_cnt_q == RETRY_LIMIT - 2'h1) begin
                            iface_valid_q <= 1'b0;
                            state_q <= E_UNREC;
                        end else begin
                            tmo_cnt_q <= tmo_cnt_q + 2'h1;
                        end
                    end
                end
                E_RST_DLY: begin
                    if (tmr_q >= TIMER_W'(RESET_DELAY_PERIOD)) begin
                        tmr_q <= '0;
                        rst_req_q <= 1'b1;
                        state_q <= E_IFC;
                    end
                end
                E_DISPOSE: begin
                    if (tmr_q >= TIMER_W'(DISPOSAL_WAIT_PERIOD)) begin
                        iface_valid_q <= 1'b0;
                        rst_req_q <= 1'b1;
                        state_q <= E_UNREC;
                    end
                end
                E_INIT_REQ: begin
                    // Entered with the timer still counting from the confirmation; restart here
                    if (!retry_q && (eq_code_q == MSG_CONF_RSP)) begin
                        tmr_q <= '0;
                        retry_q <= 1'b1;
                        eq_valid_q <= 1'b1;
                        eq_code_q <= MSG_INIT_REQ;
                        eq_arg_q <= ARG_W'(keep_data_in);
                    end else if (rx && (link.ad_code == MSG_INIT_ACC)) begin
                        retry_q <= 1'b0;
                        state_q <= E_INIT_WAIT;
                    end else if (tmr_q >= TIMER_W'(FIRST_RESPONSE_TIMEOUT)) begin
                        tmr_q <= '0;
                        if (eq_code_q == MSG_INIT_REQ && eq_arg_q[ARG_LAST_BIT]) begin
                            state_q <= E_STANDALONE;
                        end else begin
                            eq_valid_q <= 1'b1;
                            eq_arg_q[ARG_LAST_BIT] <= 1'b1;
                        end
                    end
                end
                E_INIT_WAIT: begin
                    if (rx && (link.ad_code == MSG_INIT_DONE)) begin
                        eq_valid_q <= 1'b1;
                        eq_code_q <= MSG_INIT_DONE_ACK;
                        eq_arg_q <= ARG_W'(RES_OK);
                        state_q <= E_CONSTRUCT;
                    end else if (tmr_q >= TIMER_W'(INIT_WAIT_PERIOD)) begin
                        state_q <= E_STANDALONE;
                    end
                end
                E_CONSTRUCT, E_NORMAL: begin
                    if (rx && (link.ad_code == MSG_INQ_REQ) && (state_q == E_CONSTRUCT)) begin
                        eq_valid_q <= 1'b1;
                        eq_code_q <= MSG_INQ_RSP;
                        eq_arg_q <= {(rx_obj + 8'h01 >= num_objects_in), 7'h00, rx_obj};
                    end else if (rx && (link.ad_code == MSG_INQ_DONE) && (state_q == E_CONSTRUCT)) begin
                        eq_valid_q <= 1'b1;
                        eq_code_q <= MSG_INQ_DONE_ACK;
                        eq_arg_q <= {8'h00, exp_obj_sig_in};
                    end else if (rx && (link.ad_code == MSG_STARTUP)) begin
                        eq_valid_q <= 1'b1;
                        eq_code_q <= MSG_STARTUP_ACK;
                        eq_arg_q <= ARG_W'(RES_OK);
                        state_q <= E_NORMAL;
                    end
                end
                E_STANDALONE, E_UNREC: begin
                    // Terminal until the next reset; recognition service lives elsewhere
                    state_q <= state_q;
                end
                default: begin
                    state_q <= E_IFC;
                end
            endcase
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign link.tick = tick_q;
    assign link.adapter_reset_n = adp_rst_n_q;
    assign link.eq_valid = eq_valid_q;
    assign link.eq_code = eq_code_q;
    assign link.eq_arg = eq_arg_q;
    assign eq_state_out = state_q;
    assign iface_data_valid_out = iface_valid_q;

endmodule

/* File: albs_link_assertions.sv */
// Concurrent checks on the link that joins the equipment end and the adapter end.
// Assumes one clock for both ends and the message codes of albs_pkg.
module albs_link_checker
    import albs_pkg::*;
(
    // Clock, reset and link signals
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic adapter_reset_n,
    input wire logic eq_valid,
    input wire albs_msg_t eq_code,
    input wire logic [ARG_W-1:0] eq_arg,
    input wire logic ad_valid,
    input wire albs_msg_t ad_code,
    input wire logic [ARG_W-1:0] ad_arg
);
    timeunit 1ns;
    timeprecision 1ns;
    // Once disposal is reported the equipment waits out disposal, goes unrecognized and answers no further request
    logic disposed_q;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            disposed_q <= 1'b0;
        end else if (eq_valid && eq_code == MSG_CONF_RSP && eq_arg[7:0] == RES_DISPOSE) begin
            disposed_q <= 1'b1;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    conf_answer_a:
        assert property (!disposed_q && ad_valid && ad_code == MSG_CONF_REQ |=> eq_valid && eq_code == MSG_CONF_RSP)
        else $error("confirmation request left unanswered");
    conf_result_a:
        assert property (eq_valid && eq_code == MSG_CONF_RSP |-> eq_arg[7:0] <= RES_DISPOSE)
        else $error("confirmation result out of range");
    init_request_a:
        assert property (eq_valid && eq_code == MSG_CONF_RSP && (eq_arg[7:0] == RES_OK ||
            eq_arg[7:0] == RES_OBJ_MISMATCH) |=> eq_valid && eq_code == MSG_INIT_REQ)
        else $error("no init request after accepted confirmation");
    init_done_ack_a:
        assert property (ad_valid && ad_code == MSG_INIT_DONE |=> eq_valid && eq_code == MSG_INIT_DONE_ACK)
        else $error("init completion not acknowledged");
    inquiry_answer_a:
        assert property (ad_valid && ad_code == MSG_INQ_REQ |=> eq_valid && eq_code == MSG_INQ_RSP &&
            eq_arg[7:0] == $past(ad_arg[7:0]))
        else $error("inquiry answered wrongly");
    inq_done_ack_a:
        assert property (ad_valid && ad_code == MSG_INQ_DONE |=> eq_valid && eq_code == MSG_INQ_DONE_ACK)
        else $error("inquiry completion not acknowledged");
    startup_ack_a:
        assert property (ad_valid && ad_code == MSG_STARTUP |=> eq_valid && eq_code == MSG_STARTUP_ACK)
        else $error("startup notification not acknowledged");
    reset_pulse_a:
        assert property ($fell(adapter_reset_n) |=> !adapter_reset_n [*3] ##1 adapter_reset_n)
        else $error("adapter reset pulse has wrong length");
endmodule

/* File: albs_link_if.sv */
// Link between the equipment end and the adapter end: message strobes,
// the shared time-base tick and the adapter reset line. Same clock both sides.
interface albs_link_if;
    import albs_pkg::*;

    logic tick;
    logic adapter_reset_n;
    logic eq_valid;
    albs_msg_t eq_code;
    logic [ARG_W-1:0] eq_arg;
    logic ad_valid;
    albs_msg_t ad_code;
    logic [ARG_W-1:0] ad_arg;

    modport equip (
        output tick, adapter_reset_n, eq_valid, eq_code, eq_arg,
        input ad_valid, ad_code, ad_arg
    );

    modport adapter (
        input tick, adapter_reset_n, eq_valid, eq_code, eq_arg,
        output ad_valid, ad_code, ad_arg
    );

endinterface

/* File: albs_pkg.sv */
// Shared constants and types for the adapter link bring-up sequencer.
// Assumes both ends run on the same 25 MHz clock and share one time-base tick.
package albs_pkg;

    // ****************************************
    // Clock and time base
    // ****************************************
    localparam int CLK_HZ = 25000000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;

    // ****************************************
    // Timeout periods in milliseconds (one tick each)
    // ****************************************
    localparam int RESPONSE_TIMEOUT_MS = 3000;
    localparam int INIT_WAIT_MS = 5000;
    localparam int CONFIRM_RESPONSE_MS = 3000;
    localparam int RESET_DELAY_MS = 1000;
    localparam int DISPOSAL_WAIT_MS = 5000;
    localparam int ADAPTER_CONFIRM_MS = 3000;
    localparam int ADAPTER_INIT_MS = 100;
    localparam int TIMER_W = 16;

    // ****************************************
    // Retry limits and reset pulse
    // ****************************************
    localparam logic [1:0] RETRY_LIMIT = 2'h3;
    localparam logic [3:0] RESET_PULSE_CYCLES = 4'h4;

    // ****************************************
    // Message argument layout
    // ****************************************
    localparam int ARG_W = 16;
    localparam int ARG_TYPE_LSB = 8;
    localparam int ARG_LAST_BIT = 15;
    localparam int ARG_KEEP_BIT = 0;
    localparam logic [7:0] NO_OBJECTS = 8'h00;

    // Confirmation results
    localparam logic [7:0] RES_OK = 8'h00;
    localparam logic [7:0] RES_TYPE_MISMATCH = 8'h01;
    localparam logic [7:0] RES_OBJ_MISMATCH = 8'h02;
    localparam logic [7:0] RES_DISPOSE = 8'h03;

    typedef enum logic [3:0] {
        MSG_NONE = 4'h0,
        MSG_CONF_REQ = 4'h1,
        MSG_CONF_RSP = 4'h2,
        MSG_INIT_REQ = 4'h3,
        MSG_INIT_ACC = 4'h4,
        MSG_INIT_DONE = 4'h5,
        MSG_INIT_DONE_ACK = 4'h6,
        MSG_INQ_REQ = 4'h7,
        MSG_INQ_RSP = 4'h8,
        MSG_INQ_DONE = 4'h9,
        MSG_INQ_DONE_ACK = 4'hA,
        MSG_STARTUP = 4'hB,
        MSG_STARTUP_ACK = 4'hC
    } albs_msg_t;

endpackage

/* File: albs_tb_top.sv */
// Self-checking bench: both ends joined by one link, confirmation results checked from a queue.
// Assumes albs_pkg, albs_link_if, both ends and the link checker are compiled first.
module albs_tb_top
    import albs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] exp_type = 8'h5A, exp_sig = 8'h00, num_obj = 8'h01, ad_type = 8'h5A, ret_sig = 8'h00;
    logic keep = 1'b0, ret_valid = 1'b0, iface_valid, has_obj;
    logic [8:0] eq_state, ad_state;
    logic [31:0] lfsr_q = 32'h4902F425;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int cmp_count = 0;
    albs_link_if link();
    // Short tick and the periods these scenarios reach; answer timeouts keep their defaults except the adapter confirmation timeout, cut to 8
    albs_equip_end #(.TICK_LEN(4), .RESET_DELAY_PERIOD(6), .DISPOSAL_WAIT_PERIOD(10)) albs_equip_end_inst (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .link(link), .exp_adapter_type_in(exp_type), .exp_obj_sig_in(exp_sig),
        .num_objects_in(num_obj), .keep_data_in(keep), .eq_state_out(eq_state), .iface_data_valid_out(iface_valid));
    albs_adapter_end #(.ADAPTER_CONFIRM_TIMEOUT(8), .INIT_PERIOD(2))
        albs_adapter_end_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .link(link), .adapter_type_in(ad_type),
        .retained_valid_in(ret_valid), .retained_sig_in(ret_sig), .ad_state_out(ad_state), .has_objects_out(has_obj));
    albs_link_checker albs_link_checker_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .adapter_reset_n(link.adapter_reset_n), .eq_valid(link.eq_valid), .eq_code(link.eq_code),
        .eq_arg(link.eq_arg), .ad_valid(link.ad_valid), .ad_code(link.ad_code), .ad_arg(link.ad_arg));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Each confirmation response takes the oldest noted result
    // Sampled mid-cycle, where the one-cycle strobe has settled; an unnoted response counts as a mismatch
    always @(negedge clk_in) begin
        if (reset_n_in && link.eq_valid === 1'b1 && link.eq_code === MSG_CONF_RSP) begin
            check({1'b0, link.eq_arg[7:0]},
                (exp_q.size() > 0) ? {1'b0, exp_q.pop_front()} : 9'h1FF, "conf result");
        end
    end
    task automatic run(input logic [7:0] at, rs, es, input logic rv, iv, input logic [8:0] ef, af);
        int i;
        @(negedge clk_in);
        reset_n_in = 1'b0;
        ad_type = at;
        ret_sig = rs;
        exp_sig = es;
        ret_valid = rv;
        lfsr_q = lfsr_next(lfsr_q);
        num_obj = {6'h00, lfsr_q[1:0]} + 8'h01;
        keep = lfsr_q[2];
        repeat (10) @(negedge clk_in);
        reset_n_in = 1'b1;
        for (i = 0; i < 20000 && eq_state !== ef; i++) @(negedge clk_in);
        if (i == 20000) begin
            n_fail++;
            end_of_test();
        end
        repeat (150) @(negedge clk_in);
        check(eq_state, ef, "equip state");
        check(ad_state, af, "adapter state");
        check({8'h00, iface_valid}, {8'h00, iv}, "iface valid");
        check({8'h00, has_obj}, {8'h00, af == 9'h080}, "has objects");
        check(9'(exp_q.size()), 9'h000, "pending results");
        $display("test with adapter type %h done", at);
    endtask
    initial begin
        exp_q.push_back(RES_OBJ_MISMATCH);
        run(8'h5A, 8'h00, 8'h3C, 1'b0, 1'b1, 9'h040, 9'h080);
        exp_q.push_back(RES_OK);
        run(8'h5A, 8'h3C, 8'h3C, 1'b1, 1'b1, 9'h040, 9'h080);
        exp_q.push_back(RES_OBJ_MISMATCH);
        run(8'h5A, 8'hC3, 8'h3C, 1'b1, 1'b1, 9'h040, 9'h080);
        exp_q.push_back(RES_TYPE_MISMATCH);
        exp_q.push_back(RES_TYPE_MISMATCH);
        exp_q.push_back(RES_DISPOSE);
        run(8'hA5, 8'h00, 8'h3C, 1'b0, 1'b0, 9'h100, 9'h100);
        end_of_test();
    end
endmodule
